/* File: ffm_pkg.sv */
// package: constants and carriers for the fifo flag, retransmit and mailbox block
//=============================================================
// Operation
// - almost-empty low at offset X words or fewer, high from X+1 words
// - almost-empty rises on second read-side edge after the filling write
// - almost-full low from 1024 minus Y words, high below that
// - almost-full rises on second write-side edge after the draining read
// - a word held in the output register counts as removed
// - offsets preset to eight at reset, programmable from the register port or serially on port A
// - replay request with output valid marks output word, enters replay mode
// - replay mode ends on a read-side edge with the request low
// - replay needs two or more reads past the mark; vector three words min
// - replay edge reloads the marked word; loops repeat endlessly
// - current pointer drives read flags, frozen shadow drives write flags
// - writes go on in replay mode; full flags count from the marked word
// - replay copies shadow to current pointer, output valid at once; the code loads the shadow word and sets the pointer to shadow plus one
// - leaving replay switches write flags to current pointer, two-edge sync
// - two 36-bit mailboxes; each port's select picks fifo or mailbox
// - port A mailbox write fills mailbox one, port B fills mailbox two
// - a mailbox write lowers its flag; writes ignored while flag low
// - port B shows output register or mailbox one; port A shows mailbox two
// - port B mailbox read frees flag one, port A read frees flag two
// - mailbox contents survive reads, change only on writes
// - output valid only with a new word; reads ignored while it is low
// - input space only while a location is free; writes ignored otherwise
package ffm_pkg;
	localparam int FFM_DW = 36;
	localparam int FFM_AW = 10;
	localparam int FFM_OW = 10;
	localparam logic [FFM_AW:0] FFM_DEPTH = 11'h400;
	localparam logic [FFM_OW-1:0] FFM_OFFSET_PRESET = 10'h008;
	localparam logic [1:0] FFM_MIN_REPLAY_READS = 2'h2;
	localparam int FFM_RAW = 8;
	localparam logic [7:0] FFM_REG_EMPTY_OFS = 8'h00;
	localparam logic [7:0] FFM_REG_FULL_OFS = 8'h04;
	localparam logic [7:0] FFM_REG_STATUS = 8'h08;
	localparam int FFM_ST_FILL_LSB = 0;
	localparam int FFM_ST_FLAG_LSB = 16;

	// port A pins: direction high means write
	typedef struct packed {
		logic clk;
		logic sel_n;
		logic dir;
		logic en;
		logic mbsel;
		logic ser_en;
		logic ser_bit;
		logic [FFM_DW-1:0] bus;
	} ffm_pa_in_t;

	// port B pins: direction high means read
	typedef struct packed {
		logic clk;
		logic sel_n;
		logic dir;
		logic en;
		logic mbsel;
		logic replay_mode_request;
		logic replay_from_mark;
		logic [FFM_DW-1:0] bus;
	} ffm_pb_in_t;

	typedef struct packed {
		logic [FFM_RAW-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ffm_reg_req_t;
endpackage

/* File: ffm_core.sv */
// module: fifo flags, synchronous replay and mailbox bypass registers
`timescale 1ns/10ps
module ffm_core (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire ffm_pkg::ffm_pa_in_t port_a_i,
	input wire ffm_pkg::ffm_pb_in_t port_b_i,
	input wire ffm_pkg::ffm_reg_req_t reg_req_i,
	output logic [31:0] reg_rdata_o,
	output logic [ffm_pkg::FFM_DW-1:0] port_a_bus_o,
	output logic port_a_bus_oe_o,
	output logic [ffm_pkg::FFM_DW-1:0] port_b_bus_o,
	output logic port_b_bus_oe_o,
	output logic output_valid_flag_o,
	output logic input_space_flag_o,
	output logic almost_empty_flag_n_o,
	output logic almost_full_flag_n_o,
	output logic mailbox_one_flag_n_o,
	output logic mailbox_two_flag_n_o
);
	import ffm_pkg::*;

	//=============================================================
	// pin synchronisers
	// port clocks arrive as pins; both sides are sampled by core_clk_i
	ffm_pa_in_t pa_s1, pa_s2, pa_s3;
	ffm_pb_in_t pb_s1, pb_s2, pb_s3;
	logic wa_lvl, rb_lvl;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pa_s1 <= '0;
			pa_s2 <= '0;
			pa_s3 <= '0;
			pb_s1 <= '0;
			pb_s2 <= '0;
			pb_s3 <= '0;
		end else begin
			pa_s1 <= port_a_i;
			pa_s2 <= pa_s1;
			pa_s3 <= pa_s2;
			pb_s1 <= port_b_i;
			pb_s2 <= pb_s1;
			pb_s3 <= pb_s2;
		end
	end

	// a clock level counts only once stages two and three agree
	wire wa_agree = (pa_s2.clk == pa_s3.clk);
	wire rb_agree = (pb_s2.clk == pb_s3.clk);
	wire wa_edge = wa_agree && pa_s3.clk && !wa_lvl;
	wire rb_edge = rb_agree && pb_s3.clk && !rb_lvl;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wa_lvl <= 1'b0;
			rb_lvl <= 1'b0;
		end else begin
			if (wa_agree) begin
				wa_lvl <= pa_s3.clk;
			end
			if (rb_agree) begin
				rb_lvl <= pb_s3.clk;
			end
		end
	end

	//=============================================================
	// port decode
	wire a_on = wa_edge && !pa_s3.sel_n && pa_s3.en;
	wire b_on = rb_edge && !pb_s3.sel_n && pb_s3.en;
	wire a_fifo_wr = a_on && pa_s3.dir && !pa_s3.mbsel;
	wire a_mb_wr = a_on && pa_s3.dir && pa_s3.mbsel;
	wire a_mb_rd = a_on && !pa_s3.dir && pa_s3.mbsel;
	wire b_fifo_rd = b_on && pb_s3.dir && !pb_s3.mbsel;
	wire b_mb_wr = b_on && !pb_s3.dir && pb_s3.mbsel;
	wire b_mb_rd = b_on && pb_s3.dir && pb_s3.mbsel;

	//=============================================================
	// storage and pointers
	logic [FFM_DW-1:0] mem [0:(1 << FFM_AW)-1];
	logic [FFM_AW:0] wptr, rptr, shadow;
	logic [FFM_AW:0] wptr_rs1, wptr_rs2, rp_ws1;
	logic [FFM_DW-1:0] out_reg;
	logic or_flag, ir_flag, ae_n, af_n;
	logic rt_active;
	logic [1:0] rt_reads;
	logic [FFM_OW-1:0] ofs_x, ofs_y;

	// output register holds a word already gone from memory
	wire [FFM_AW:0] avail = wptr_rs2 - rptr;
	wire rt_go = rt_active && pb_s3.replay_mode_request && pb_s3.replay_from_mark
		&& (rt_reads >= FFM_MIN_REPLAY_READS);
	wire want_word = or_flag ? b_fifo_rd : 1'b1;
	wire load_word = rb_edge && !rt_go && want_word && (avail != '0);
	wire rt_enter = rb_edge && !rt_active && pb_s3.replay_mode_request && or_flag;
	wire rt_leave = rb_edge && rt_active && !pb_s3.replay_mode_request;
	wire [FFM_AW:0] mark_ptr = rptr - 11'h001;
	wire [FFM_AW:0] shadow_next = shadow + 11'h001;
	wire [FFM_AW:0] next_rptr = (rb_edge && rt_go) ? shadow_next :
		(load_word ? rptr + 11'h001 : rptr);

	// write side judges free space from the frozen mark in replay mode
	wire [FFM_AW:0] rp_for_w = rt_active ? shadow : rptr;
	wire wr_take = a_fifo_wr && ir_flag;
	wire [FFM_AW:0] next_wptr = wr_take ? wptr + 11'h001 : wptr;
	wire [FFM_AW:0] wr_count = next_wptr - rp_ws1;
	wire [FFM_AW:0] full_mark = FFM_DEPTH - {1'b0, ofs_y};
	wire [FFM_AW:0] rd_count = wptr_rs1 - next_rptr;

	always_ff @(posedge core_clk_i) begin
		if (wr_take) begin
			mem[wptr[FFM_AW-1:0]] <= pa_s3.bus;
		end
	end

	//=============================================================
	// write side: pointer and flags on write-side edges
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wptr <= '0;
			rp_ws1 <= '0;
			ir_flag <= 1'b0;
			af_n <= 1'b1;
		end else if (wa_edge) begin
			wptr <= next_wptr;
			rp_ws1 <= rp_for_w;
			ir_flag <= (wr_count < FFM_DEPTH);
			af_n <= (wr_count < full_mark);
		end
	end

	//=============================================================
	// read side: output register, replay and flags on read-side edges
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rptr <= '0;
			wptr_rs1 <= '0;
			wptr_rs2 <= '0;
			out_reg <= '0;
			or_flag <= 1'b0;
			ae_n <= 1'b0;
		end else if (rb_edge) begin
			wptr_rs1 <= wptr;
			wptr_rs2 <= wptr_rs1;
			rptr <= next_rptr;
			ae_n <= (rd_count > {1'b0, ofs_x});
			if (rt_go) begin
				out_reg <= mem[shadow[FFM_AW-1:0]];
				or_flag <= 1'b1;
			end else if (load_word) begin
				out_reg <= mem[rptr[FFM_AW-1:0]];
				or_flag <= 1'b1;
			end else if (b_fifo_rd) begin
				or_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rt_active <= 1'b0;
			shadow <= '0;
			rt_reads <= '0;
		end else if (rt_enter) begin
			rt_active <= 1'b1;
			shadow <= mark_ptr;
			rt_reads <= '0;
		end else if (rt_leave) begin
			rt_active <= 1'b0;
		end else if (rb_edge && rt_go) begin
			rt_reads <= '0;
		end else if (load_word && rt_active
			&& rt_reads < FFM_MIN_REPLAY_READS) begin
			rt_reads <= rt_reads + 2'h1;
		end
	end

	//=============================================================
	// mailboxes
	logic [FFM_DW-1:0] mailbox_one, mailbox_two;
	logic mb1_n, mb2_n;
	wire mb1_take = a_mb_wr && mb1_n;
	wire mb2_take = b_mb_wr && mb2_n;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mailbox_one <= '0;
			mailbox_two <= '0;
			mb1_n <= 1'b1;
			mb2_n <= 1'b1;
		end else begin
			if (mb1_take) begin
				mailbox_one <= pa_s3.bus;
			end
			if (mb2_take) begin
				mailbox_two <= pb_s3.bus;
			end
			// a take needs the flag high, so a release in the same cycle has nothing to free and the take wins
			if (mb1_take) begin
				mb1_n <= 1'b0;
			end else if (b_mb_rd) begin
				mb1_n <= 1'b1;
			end
			if (mb2_take) begin
				mb2_n <= 1'b0;
			end else if (a_mb_rd) begin
				mb2_n <= 1'b1;
			end
		end
	end

	//=============================================================
	// offset registers and software port
	wire reg_x_wr = reg_req_i.wr && (reg_req_i.addr == FFM_REG_EMPTY_OFS);
	wire reg_y_wr = reg_req_i.wr && (reg_req_i.addr == FFM_REG_FULL_OFS);
	wire ser_shift = wa_edge && pa_s3.ser_en;
	wire [2*FFM_OW-1:0] ser_next = {ofs_y[FFM_OW-2:0], ofs_x, pa_s3.ser_bit};
	wire [FFM_AW:0] fill = wptr - rptr;
	wire [31:0] status_word = {11'h000,
		rt_active, or_flag, ae_n, af_n, ir_flag, 5'h00, fill};
	wire [31:0] rd_mux =
		(reg_req_i.addr == FFM_REG_EMPTY_OFS) ? {22'h000000, ofs_x} :
		(reg_req_i.addr == FFM_REG_FULL_OFS) ? {22'h000000, ofs_y} :
		(reg_req_i.addr == FFM_REG_STATUS) ? status_word : 32'h00000000;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ofs_x <= FFM_OFFSET_PRESET;
			ofs_y <= FFM_OFFSET_PRESET;
			reg_rdata_o <= '0;
		end else begin
			if (reg_x_wr) begin
				ofs_x <= reg_req_i.wdata[FFM_OW-1:0];
			end else if (reg_y_wr) begin
				ofs_y <= reg_req_i.wdata[FFM_OW-1:0];
			end else if (ser_shift) begin
				{ofs_y, ofs_x} <= ser_next;
			end
			reg_rdata_o <= reg_req_i.rd ? rd_mux : 32'h00000000;
		end
	end

	//=============================================================
	// data pins, registered
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_a_bus_o <= '0;
			port_a_bus_oe_o <= 1'b0;
			port_b_bus_o <= '0;
			port_b_bus_oe_o <= 1'b0;
		end else begin
			port_a_bus_o <= mailbox_two;
			port_a_bus_oe_o <= !pa_s3.sel_n && !pa_s3.dir;
			port_b_bus_o <= pb_s3.mbsel ? mailbox_one : out_reg;
			port_b_bus_oe_o <= !pb_s3.sel_n && pb_s3.dir;
		end
	end

	assign output_valid_flag_o = or_flag;
	assign input_space_flag_o = ir_flag;
	assign almost_empty_flag_n_o = ae_n;
	assign almost_full_flag_n_o = af_n;
	assign mailbox_one_flag_n_o = mb1_n;
	assign mailbox_two_flag_n_o = mb2_n;

	//=============================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	mbox_store_a: assert property (
		a_mb_wr && mb1_n |=> !mb1_n && mailbox_one == $past(pa_s3.bus))
		else $error("mailbox one not stored");
	mbox_hold_a: assert property (
		a_mb_wr && !mb1_n |=> $stable(mailbox_one))
		else $error("mailbox one overwritten while full");
	mbox_release_a: assert property (
		b_mb_rd && !a_mb_wr |=> mb1_n && $stable(mailbox_one))
		else $error("mailbox one flag not released");
	read_ignore_a: assert property (
		b_fifo_rd && !or_flag && avail == '0 && !rt_go |=> $stable(rptr))
		else $error("read taken without output valid");
	write_ignore_a: assert property (
		a_fifo_wr && !ir_flag |=> $stable(wptr))
		else $error("write taken without space");
	replay_enter_a: assert property (
		rt_enter |=> rt_active && shadow == $past(rptr) - 11'h001)
		else $error("replay mark wrong");
	replay_exit_a: assert property (
		rt_leave |=> !rt_active ##1 $stable(shadow))
		else $error("replay mode not left");
	replay_jump_a: assert property (
		rb_edge && rt_go |=> or_flag && rptr == $past(shadow) + 11'h001)
		else $error("replay did not reload");
	flag_timing_a: assert property (
		!rb_edge |=> $stable(ae_n) && $stable(or_flag))
		else $error("read flag moved off a read edge");
endmodule

/* File: ffm_port_model.sv */
// partner model: a synchronous processor port facing one side of the fifo
`timescale 1ns/10ps
module ffm_port_model #(
	parameter int HALF = 5
) (
	input wire logic core_clk_i,
	output logic clk_o,
	output logic [3:0] ctl_o,
	output logic [1:0] aux_o,
	output logic [35:0] bus_o
);
	int cnt;

	initial begin
		clk_o = 1'b0;
		cnt = 0;
		ctl_o = 4'h8;
		aux_o = 2'h0;
		bus_o = 36'h0;
	end

	//==========
	// free-running port clock, stepped on core edges
	always @(posedge core_clk_i) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			clk_o <= ~clk_o;
		end
	end

	//==========
	// pins change on the fall, so they stand a half period around the rise
	task automatic op(input logic [3:0] c, input logic [1:0] x,
		input logic [35:0] d);
		@(negedge clk_o);
		ctl_o <= c;
		aux_o <= x;
		bus_o <= d;
		@(negedge clk_o);
		ctl_o <= {c[3:2], 1'b0, c[0]};
		aux_o <= {x[1], 1'b0};
		// released bus must not keep showing the last word
		bus_o <= ~d;
	endtask
endmodule

/* File: ffm_core_tb.sv */
// testbench: fifo flags, replay and mailboxes against a queue model
`timescale 1ns/10ps
module ffm_core_tb;
	import ffm_pkg::*;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	ffm_reg_req_t req = '0;
	logic [31:0] rdata;
	logic [35:0] a_out, b_out, da, db, d;
	logic a_oe, b_oe, ov, isf, ae_n, af_n, mb1_n, mb2_n, ca, cb;
	logic [3:0] ka, kb;
	logic [1:0] xa, xb;
	int mismatches = 0;
	int check_count = 0;
	logic [35:0] wq[$];
	int rp, mark;

	always #5 core_clk_i = ~core_clk_i;

	ffm_port_model #(.HALF(5)) u_pa (.core_clk_i(core_clk_i), .clk_o(ca),
		.ctl_o(ka), .aux_o(xa), .bus_o(da));
	ffm_port_model #(.HALF(6)) u_pb (.core_clk_i(core_clk_i), .clk_o(cb),
		.ctl_o(kb), .aux_o(xb), .bus_o(db));

	ffm_core u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.port_a_i({ca, ka, xa, da}), .port_b_i({cb, kb, xb, db}),
		.reg_req_i(req), .reg_rdata_o(rdata), .port_a_bus_o(a_out),
		.port_a_bus_oe_o(a_oe), .port_b_bus_o(b_out),
		.port_b_bus_oe_o(b_oe), .output_valid_flag_o(ov),
		.input_space_flag_o(isf), .almost_empty_flag_n_o(ae_n),
		.almost_full_flag_n_o(af_n), .mailbox_one_flag_n_o(mb1_n),
		.mailbox_two_flag_n_o(mb2_n));

	//==========
	// checking helpers
	task automatic chk(input logic [35:0] act, input logic [35:0] exp);
		check_count++;
		if (act !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask

	task automatic wait_flag(ref logic f, input logic v);
		int n;
		n = 0;
		while (f !== v && n < 200) begin
			@(posedge core_clk_i);
			n++;
		end
		#1;
		chk({35'h0, f}, {35'h0, v});
	endtask

	function automatic logic [35:0] rnd();
		logic [63:0] r;
		r = {$urandom, $urandom};
		return r[35:0];
	endfunction

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge core_clk_i);
		req.wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge core_clk_i);
		req.rd <= 1'b0;
		#1;
		chk({4'h0, rdata}, {4'h0, v});
	endtask

	// fifo read on port b, model pointer follows it
	task automatic rd_b(input logic [1:0] x);
		u_pb.op(4'b0110, x, 36'h0);
		rp++;
		chk(b_out, wq[rp]);
	endtask

	task automatic results();
		if (mismatches == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		results();
	end

	//==========
	// main sequence
	initial begin
		void'($urandom(32'h05594068));
		repeat (3) @(posedge core_clk_i);
		#1;
		chk({31'h0, ov, ae_n, af_n, mb1_n, mb2_n}, 36'h7);
		@(posedge core_clk_i);
		arst_n_i <= 1'b1;
		reg_rd(FFM_REG_EMPTY_OFS, 32'h8);
		reg_rd(FFM_REG_FULL_OFS, 32'h8);
		reg_rd(8'hFC, 32'h0);
		reg_wr(FFM_REG_FULL_OFS, 32'h3F6);
		reg_rd(FFM_REG_FULL_OFS, 32'h3F6);
		wait_flag(isf, 1'b1);
		d = rnd();
		u_pa.op(4'b0111, 2'h0, d);
		wait_flag(mb1_n, 1'b0);
		u_pa.op(4'b0111, 2'h0, ~d);
		u_pb.op(4'b0111, 2'h0, 36'h0);
		chk(b_out, d);
		wait_flag(mb1_n, 1'b1);
		u_pb.op(4'b0111, 2'h0, 36'h0);
		chk(b_out, d);
		d = rnd();
		u_pb.op(4'b0011, 2'h0, d);
		wait_flag(mb2_n, 1'b0);
		u_pa.op(4'b0011, 2'h0, 36'h0);
		chk({a_oe, a_out[34:0]}, {1'b1, d[34:0]});
		chk(a_out, d);
		wait_flag(mb2_n, 1'b1);
		for (int i = 0; i < 12; i++) begin
			wq.push_back(rnd());
			u_pa.op(4'b0110, 2'h0, wq[i]);
			if (i == 8) begin
				wait_flag(ov, 1'b1);
				repeat (60) @(posedge core_clk_i);
				chk({35'h0, ae_n}, 36'h0);
			end
			if (i == 9) begin
				wait_flag(ae_n, 1'b1);
				chk({35'h0, af_n}, 36'h1);
			end
		end
		wait_flag(af_n, 1'b0);
		rp = 0;
		// port b still selects the mailbox until this op clears mbsel
		u_pb.op(4'b0100, 2'b10, 36'h0);
		chk(b_out, wq[0]);
		mark = rp;
		rd_b(2'b10);
		rd_b(2'b10);
		u_pb.op(4'b0100, 2'b11, 36'h0);
		rp = mark;
		chk(b_out, wq[rp]);
		rd_b(2'b10);
		repeat (60) @(posedge core_clk_i);
		chk({35'h0, af_n}, 36'h0);
		u_pb.op(4'b0100, 2'b00, 36'h0);
		rd_b(2'b00);
		rd_b(2'b00);
		wait_flag(af_n, 1'b1);
		while (rp < 11) begin
			rd_b(2'b00);
		end
		u_pb.op(4'b0110, 2'h0, 36'h0);
		wait_flag(ov, 1'b0);
		u_pb.op(4'b0110, 2'h0, 36'h0);
		chk(b_out, wq[11]);
		chk({35'h0, ae_n}, 36'h0);
		// empty fifo: input space and almost-full high, all else low
		reg_rd(FFM_REG_STATUS, 32'h00030000);
		results();
	end
endmodule
